/* File: verilog/fpc_pkg.sv */
package fpc_pkg;
   // propagation_config_register layout
   localparam int unsigned PROP_PHASE_BIT = 0;
   localparam int unsigned PROP_OV_BIT    = 1;
   localparam int unsigned PROP_UV_BIT    = 2;
   localparam int unsigned PROP_OC_BIT    = 3;
   localparam int unsigned PROP_OT_BIT    = 4;
   localparam int unsigned PROP_TR_BIT    = 5;
   localparam int unsigned REPORT_PG_BIT  = 6;
   localparam int unsigned REPORT_PT_BIT  = 7;
   localparam logic [7:0]  PROP_CFG_RESET = 8'h3f;

   // controller register offsets
   localparam logic [3:0] ADDR_PROP_CFG  = 4'h0;
   localparam logic [3:0] ADDR_CONTROL   = 4'h1;
   localparam logic [3:0] ADDR_STATUS    = 4'h2;
   localparam logic [3:0] ADDR_FAULTS    = 4'h3;
   localparam logic [3:0] ADDR_LATCH_CFG = 4'h4;
   localparam logic [3:0] ADDR_MGR_CTRL  = 4'h0;
   localparam logic [3:0] ADDR_MGR_STAT  = 4'h1;

   // protection index in the six-bit fault vector
   localparam int unsigned FLT_PHASE = 0;
   localparam int unsigned FLT_OV    = 1;
   localparam int unsigned FLT_UV    = 2;
   localparam int unsigned FLT_OC    = 3;
   localparam int unsigned FLT_OT    = 4;
   localparam int unsigned FLT_TR    = 5;
   localparam logic [5:0] ERROR_MASK = 6'h03;

   // timing
   localparam int unsigned CLK_MHZ       = 125;
   localparam int unsigned HICCUP_MS     = 130;
   localparam int unsigned HICCUP_CYCLES = HICCUP_MS * 1000 * CLK_MHZ;

   localparam int unsigned MAX_GROUPS = 4;
   localparam int unsigned MAX_PER_GROUP = 32;

   typedef enum logic [5:0] {
      ST_OFF     = 6'b000001,
      ST_RAMP_UP = 6'b000010,
      ST_ON      = 6'b000100,
      ST_REG_OFF = 6'b001000,
      ST_FAST_OFF= 6'b010000,
      ST_HICCUP  = 6'b100000
   } fpc_state_t;
endpackage

/* File: verilog/fpc_fault_if.sv */
`timescale 1ns/100ps
interface fpc_fault_if #(parameter int unsigned GROUPS = 4);
   // per-group open-drain fault line, resolved from enables
   logic [GROUPS-1:0] convPullEn;
   logic [GROUPS-1:0] mgrPullEn;
   logic [GROUPS-1:0] tempWarn;
   logic [GROUPS-1:0] powerGoodWarn;
   logic [GROUPS-1:0] faultLineOut;
   logic [GROUPS-1:0] faultLineIn;

   assign faultLineOut = '0;
   assign faultLineIn  = ~(convPullEn | mgrPullEn);

   modport converter (
      input  faultLineIn,
      output convPullEn,
      output tempWarn,
      output powerGoodWarn
   );
   modport manager (
      input  faultLineIn,
      input  convPullEn,
      input  tempWarn,
      input  powerGoodWarn,
      output mgrPullEn
   );
endinterface // fpc_fault_if

/* File: verilog/fpc_load_converter.sv */
// Added by the designer: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
// Overview of operation
// - own enabled fault pulls group line low
// - low line from others starts turn-off
// - one to 32 converters per group
// - eight-bit config: reporting and propagation enables
// - reset 0x3f, all bits read/write
// - manager spreads low line to groups
// - manager supervises at most four groups
// - manager may stop front end, crowbar
// - propagated fault gives regular turn-off
// - originator uses its own fault's style
// - propagated error gives fast turn-off; code turns off regular unless own error active
// - own error: fast off, low-side on
// - regular off honours delay and slew
// - non-latching retries every 130ms
// - hiccup timed from zero output
// - overvoltage above prebias, error, always on
// - temp warning only signals manager
// - overcurrent: fast off, propagates regular
// - fast off without own error opens both switches
// - latching protection stays off; code goes to ST_OFF, which ramps up again when enabled and the fault clears
module fpc_load_converter #(
   parameter int unsigned GROUP        = 0,
   parameter int unsigned GROUPS       = 4,
   parameter int unsigned HICCUP_COUNT = fpc_pkg::HICCUP_CYCLES
) (
   input  wire logic       clk,
   input  wire logic       rst_n,
   fpc_fault_if.converter  link,
   input  wire logic [3:0] addr,
   input  wire logic [7:0] wrData,
   input  wire logic       wrStrobe,
   input  wire logic       rdStrobe,
   output logic [7:0]      rdData,
   input  wire logic [5:0] faultDetect,
   input  wire logic       tempWarnDetect,
   input  wire logic       powerGoodLow,
   input  wire logic       aboveprebias,
   input  wire logic       outputAtZero,
   input  wire logic       rampDone,
   input  wire logic       offDelayDone,
   output logic            highSideEn,
   output logic            lowSideEn,
   output logic            rampUpReq,
   output logic            rampDownReq
);
   logic [7:0]         propCfg_reg;
   logic [7:0]         latchCfg_reg;
   logic               enable_reg;
   logic [5:0]         faultSticky_reg;
   logic [1:0]         lineSync_reg;
   logic               pulling_reg;
   logic [1:0]         pullDly_reg;
   logic [31:0]        hiccupCnt_reg;
   fpc_pkg::fpc_state_t state_reg;
   logic [5:0]         active;
   logic [5:0]         propMask;
   logic               ownFault;
   logic               ownFast;
   logic               ownError;
   logic               latchHit;
   logic               lineLow;
   logic               fromOthers;

   // protections gated by when they may act
   always_comb begin
      active = faultDetect;
      active[fpc_pkg::FLT_OV] = faultDetect[fpc_pkg::FLT_OV] & aboveprebias;
      active[fpc_pkg::FLT_OC] = faultDetect[fpc_pkg::FLT_OC] & aboveprebias;
      active[fpc_pkg::FLT_TR] = faultDetect[fpc_pkg::FLT_TR] & propCfg_reg[fpc_pkg::PROP_TR_BIT]
                                & (state_reg == fpc_pkg::ST_RAMP_UP);
      active[fpc_pkg::FLT_UV] = faultDetect[fpc_pkg::FLT_UV] & (state_reg == fpc_pkg::ST_ON);
   end

   // enables line up bit for bit with the fault vector
   assign propMask   = propCfg_reg[5:0];
   assign ownFault   = |active & ((state_reg == fpc_pkg::ST_ON) | (state_reg == fpc_pkg::ST_RAMP_UP));
   assign ownError   = |(active & fpc_pkg::ERROR_MASK);
   // oc, tr and errors are fast for the originator; uv, ot regular
   assign ownFast    = ownError | active[fpc_pkg::FLT_OC] | active[fpc_pkg::FLT_TR];
   assign latchHit   = |(active & latchCfg_reg[5:0]);
   assign lineLow    = ~lineSync_reg[1];
   // ignore our own pull, and its echo through the synchroniser, so we only react to peers
   assign fromOthers = lineLow & ~pulling_reg & ~pullDly_reg[1];

   // two-flop synchroniser on the shared line
   always_ff @(posedge clk) begin
      if (!rst_n) lineSync_reg <= 2'b11;
      else lineSync_reg <= {lineSync_reg[0], link.faultLineIn[GROUP]};
   end

   // register writes
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         propCfg_reg  <= fpc_pkg::PROP_CFG_RESET;
         latchCfg_reg <= 8'h00;
         enable_reg   <= 1'b0;
      end else if (wrStrobe) begin
         if (addr == fpc_pkg::ADDR_PROP_CFG) propCfg_reg <= wrData;
         if (addr == fpc_pkg::ADDR_LATCH_CFG) latchCfg_reg <= wrData;
         if (addr == fpc_pkg::ADDR_CONTROL) enable_reg <= wrData[0];
      end
   end

   // sticky fault record, set wins over clear-by-write
   always_ff @(posedge clk) begin
      if (!rst_n) faultSticky_reg <= 6'h00;
      else if (wrStrobe && addr == fpc_pkg::ADDR_FAULTS) faultSticky_reg <= (faultSticky_reg & ~wrData[5:0]) | active;
      else faultSticky_reg <= faultSticky_reg | active;
   end

   // read data one cycle after strobe
   always_ff @(posedge clk) begin
      if (!rst_n) rdData <= 8'h00;
      else if (rdStrobe) begin
         unique case (addr)
            fpc_pkg::ADDR_PROP_CFG:  rdData <= propCfg_reg;
            fpc_pkg::ADDR_CONTROL:   rdData <= {7'h00, enable_reg};
            fpc_pkg::ADDR_STATUS:    rdData <= {lineLow, pulling_reg, state_reg};
            fpc_pkg::ADDR_FAULTS:    rdData <= {2'b00, faultSticky_reg};
            fpc_pkg::ADDR_LATCH_CFG: rdData <= latchCfg_reg;
            default:                 rdData <= 8'h00;
         endcase
      end else rdData <= 8'h00;
   end

   // pull the group line on our enabled fault, hold until ramp-up or off
   always_ff @(posedge clk) begin
      if (!rst_n) pulling_reg <= 1'b0;
      else if (ownFault && |(active & propMask)) pulling_reg <= 1'b1;
      else if (state_reg == fpc_pkg::ST_RAMP_UP || state_reg == fpc_pkg::ST_OFF)
         pulling_reg <= 1'b0;
   end

   // own pull delayed to line up with the synchroniser, else release looks like a peer
   always_ff @(posedge clk) begin
      if (!rst_n) pullDly_reg <= 2'b00;
      else pullDly_reg <= {pullDly_reg[0], pulling_reg};
   end

   // power state machine
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_reg     <= fpc_pkg::ST_OFF;
         hiccupCnt_reg <= 32'h0;
      end else begin
         unique case (state_reg)
            fpc_pkg::ST_OFF:
               if (enable_reg && !lineLow && ~|active) state_reg <= fpc_pkg::ST_RAMP_UP;
            fpc_pkg::ST_RAMP_UP, fpc_pkg::ST_ON: begin
               if (ownFault) state_reg <= ownFast ? fpc_pkg::ST_FAST_OFF : fpc_pkg::ST_REG_OFF;
               else if (fromOthers) state_reg <= fpc_pkg::ST_REG_OFF;
               else if (!enable_reg) state_reg <= fpc_pkg::ST_REG_OFF;
               else if (state_reg == fpc_pkg::ST_RAMP_UP && rampDone) state_reg <= fpc_pkg::ST_ON;
            end
            fpc_pkg::ST_REG_OFF:
               if (fromOthers && ownError) state_reg <= fpc_pkg::ST_FAST_OFF;
               else if (outputAtZero) begin
                  hiccupCnt_reg <= 32'h0;
                  state_reg <= (latchHit || !enable_reg) ? fpc_pkg::ST_OFF : fpc_pkg::ST_HICCUP;
               end
            fpc_pkg::ST_FAST_OFF:
               if (outputAtZero) begin
                  hiccupCnt_reg <= 32'h0;
                  state_reg <= (latchHit || !enable_reg) ? fpc_pkg::ST_OFF : fpc_pkg::ST_HICCUP;
               end
            fpc_pkg::ST_HICCUP: begin
               hiccupCnt_reg <= hiccupCnt_reg + 32'h1;
               if (hiccupCnt_reg >= HICCUP_COUNT - 1) begin
                  hiccupCnt_reg <= 32'h0;
                  if (~|active && !fromOthers) state_reg <= fpc_pkg::ST_RAMP_UP;
               end
            end
            default: state_reg <= fpc_pkg::ST_OFF;
         endcase
      end
   end

   // switch drive; regular ramp waits for delay then slews
   always_comb begin
      highSideEn  = (state_reg == fpc_pkg::ST_RAMP_UP) | (state_reg == fpc_pkg::ST_ON)
                    | ((state_reg == fpc_pkg::ST_REG_OFF) & !outputAtZero);
      lowSideEn   = ((state_reg == fpc_pkg::ST_FAST_OFF) & ownError);
      if (state_reg == fpc_pkg::ST_FAST_OFF) highSideEn = 1'b0;
      rampUpReq   = (state_reg == fpc_pkg::ST_RAMP_UP);
      rampDownReq = (state_reg == fpc_pkg::ST_REG_OFF) & offDelayDone;
   end

   // warnings report only; they never change state
   // only our own group's lane is driven, the others stay released
   for (genvar g = 0; g < GROUPS; g++) begin : g_lane
      assign link.convPullEn[g]    = (g == GROUP) ? pulling_reg : 1'b0;
      assign link.tempWarn[g]      = (g == GROUP) ? (tempWarnDetect & propCfg_reg[fpc_pkg::REPORT_PT_BIT]) : 1'b0;
      assign link.powerGoodWarn[g] = (g == GROUP) ? (powerGoodLow & propCfg_reg[fpc_pkg::REPORT_PG_BIT]) : 1'b0;
   end
endmodule // fpc_load_converter

/* File: verilog/fpc_power_manager.sv */
`timescale 1ns/100ps
module fpc_power_manager #(
   parameter int unsigned GROUPS = 4
) (
   input  wire logic       clk,
   input  wire logic       rst_n,
   fpc_fault_if.manager    link,
   input  wire logic [3:0] addr,
   input  wire logic [7:0] wrData,
   input  wire logic       wrStrobe,
   input  wire logic       rdStrobe,
   output logic [7:0]      rdData,
   output logic            frontEndOff,
   output logic            crowbarFire
);
   logic [GROUPS-1:0] sync1_reg;
   logic [GROUPS-1:0] sync2_reg;
   logic [GROUPS-1:0] spreadEn_reg;
   logic              errorMode_reg;
   logic [GROUPS-1:0] pull_reg;
   logic [GROUPS-1:0] pullDly1_reg;
   logic [GROUPS-1:0] pullDly2_reg;
   logic [GROUPS-1:0] peerLow;
   logic              anyPeer;

   // line low but not by us; delayed pull masks our echo after release
   assign peerLow = ~sync2_reg & ~pull_reg & ~pullDly2_reg;
   assign anyPeer = |(peerLow & spreadEn_reg);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sync1_reg    <= '1;
         sync2_reg    <= '1;
         pullDly1_reg <= '0;
         pullDly2_reg <= '0;
      end else begin
         sync1_reg    <= link.faultLineIn;
         sync2_reg    <= sync1_reg;
         pullDly1_reg <= pull_reg;
         pullDly2_reg <= pullDly1_reg;
      end
   end

   // control: spread enables and error mode
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         spreadEn_reg  <= '0;
         errorMode_reg <= 1'b0;
      end else if (wrStrobe && addr == fpc_pkg::ADDR_MGR_CTRL) begin
         spreadEn_reg  <= wrData[GROUPS-1:0];
         errorMode_reg <= wrData[7];
      end
   end

   // hold other groups low while the source group stays low
   always_ff @(posedge clk) begin
      if (!rst_n) pull_reg <= '0;
      else if (anyPeer) pull_reg <= spreadEn_reg & ~peerLow;
      else pull_reg <= '0;
   end

   // front end and crowbar on error propagation
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         frontEndOff <= 1'b0;
         crowbarFire <= 1'b0;
      end else begin
         frontEndOff <= errorMode_reg & anyPeer;
         crowbarFire <= errorMode_reg & anyPeer;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) rdData <= 8'h00;
      else if (rdStrobe && addr == fpc_pkg::ADDR_MGR_STAT) rdData <= 8'(~sync2_reg);
      else if (rdStrobe && addr == fpc_pkg::ADDR_MGR_CTRL) rdData <= {errorMode_reg, 7'(spreadEn_reg)};
      else rdData <= 8'h00;
   end

   assign link.mgrPullEn = pull_reg;
endmodule // fpc_power_manager

/* File: verification/fpc_link_checker.sv */
`timescale 1ns/100ps
module fpc_link_checker (
   input wire logic       clk,
   input wire logic       rst_n,
   input wire logic [1:0] convPullEn,
   input wire logic [1:0] mgrPullEn,
   input wire logic [1:0] faultLineIn,
   input wire logic [1:0] tempWarn,
   input wire logic [1:0] powerGoodWarn
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // open-drain wire resolution, both groups
   line_resolve_a: assert property (faultLineIn == ~(convPullEn | mgrPullEn))
      else $error("fault line level wrong");
   // manager pulls only after a low line has been seen
   spread_cause_a: assert property ($rose(mgrPullEn[1]) |-> $past(faultLineIn[0], 2) == 1'b0)
      else $error("group 1 pulled without cause");
   spread_back_a: assert property ($rose(mgrPullEn[0]) |-> $past(faultLineIn[1], 2) == 1'b0)
      else $error("group 0 pulled without cause");
   // quiet source means manager lets go
   spread_release_a: assert property ((faultLineIn[0] && !convPullEn[1]) [*6] |-> !mgrPullEn[1])
      else $error("group 1 still pulled");
   pull_holds_a: assert property ($rose(convPullEn[0]) |=> convPullEn[0] [*3])
      else $error("converter pull too short");
   // warning reaches the manager but never the line
   warn_quiet_a: assert property ($rose(tempWarn[0]) |-> !convPullEn[0])
      else $error("warning pulled the line");
   reset_quiet_a: assert property ($rose(rst_n) |-> convPullEn == 2'h0 && mgrPullEn == 2'h0)
      else $error("pull active after reset");
   report_reset_a: assert property (!$past(rst_n) |-> tempWarn == 2'h0 && powerGoodWarn == 2'h0)
      else $error("report active after reset");
   cover property ($rose(mgrPullEn[1]));
   cover property ($rose(convPullEn[0]));
   cover property ($rose(tempWarn[0]));
endmodule // fpc_link_checker

/* File: verification/fault_propagation_control_tb.sv */
`timescale 1ns/100ps
module fault_propagation_control_tb;
   logic       clk, rst_n, tw, oaz, rdn, odd;
   logic [3:0] addr;
   logic [7:0] wrData, rdA, rdB, rdM, v;
   logic [2:0] wrS, rdS;
   logic [5:0] flt;
   logic       hs, ls, ru, rdq, rdq1, pgl, abp, hsB, lsB, ruB, feo, cbf;
   logic [5:0] fltB;
   int         err_count, checks, n;
   fpc_fault_if #(.GROUPS(2)) linkA();
   fpc_fault_if #(.GROUPS(2)) linkB();
   // one converter per group line here, inside the one to 32 allowed
   fpc_load_converter #(.GROUP(0), .GROUPS(2), .HICCUP_COUNT(20)) u_fpc_load_converter (.clk(clk), .rst_n(rst_n),
      .link(linkA.converter), .addr(addr), .wrData(wrData), .wrStrobe(wrS[0]), .rdStrobe(rdS[0]), .rdData(rdA),
      .faultDetect(flt), .tempWarnDetect(tw), .powerGoodLow(pgl), .aboveprebias(abp), .outputAtZero(oaz),
      .rampDone(rdn), .offDelayDone(odd), .highSideEn(hs), .lowSideEn(ls), .rampUpReq(ru), .rampDownReq(rdq));
   // second converter on its own line, pulled by the bench as a peer
   fpc_load_converter #(.GROUP(0), .GROUPS(2), .HICCUP_COUNT(20)) u_fpc_load_converter_b (.clk(clk), .rst_n(rst_n),
      .link(linkB.converter), .addr(addr), .wrData(wrData), .wrStrobe(wrS[1]), .rdStrobe(rdS[1]), .rdData(rdB),
      .faultDetect(fltB), .tempWarnDetect(tw), .powerGoodLow(pgl), .aboveprebias(abp), .outputAtZero(oaz),
      .rampDone(rdn), .offDelayDone(odd), .highSideEn(hsB), .lowSideEn(lsB), .rampUpReq(ruB), .rampDownReq(rdq1));
   // manager sees two groups, within its limit of four
   fpc_power_manager #(.GROUPS(2)) u_fpc_power_manager (.clk(clk), .rst_n(rst_n), .link(linkA.manager),
      .addr(addr), .wrData(wrData), .wrStrobe(wrS[2]), .rdStrobe(rdS[2]), .rdData(rdM),
      .frontEndOff(feo), .crowbarFire(cbf));
   fpc_link_checker u_fpc_link_checker (.clk(clk), .rst_n(rst_n), .convPullEn(linkA.convPullEn),
      .mgrPullEn(linkA.mgrPullEn), .faultLineIn(linkA.faultLineIn), .tempWarn(linkA.tempWarn),
      .powerGoodWarn(linkA.powerGoodWarn));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %0t saw %h wanted %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input int i, input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wrData <= d;
      wrS <= 3'h1 << i;
      @(posedge clk);
      wrS <= 3'h0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd(input int i, input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rdS <= 3'h1 << i;
      @(posedge clk);
      rdS <= 3'h0;
      #1 d = (i == 0) ? rdA : (i == 1) ? rdB : rdM;
   endtask
   task automatic wait_state(input int i, input logic [5:0] st);
      for (int k = 0; k < 60; k++) begin
         rd(i, fpc_pkg::ADDR_STATUS, v);
         if (v[5:0] === st) break;
      end
      check({2'h0, v[5:0]}, {2'h0, st});
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // hang guard
   initial begin
      repeat (30000) @(posedge clk);
      err_count++;
      tally_and_finish();
   end
   initial begin
      {rst_n, tw, oaz, rdn, odd, addr, wrData, wrS, rdS, flt, fltB, pgl} = '0;
      abp = 1'b1;
      linkB.mgrPullEn = 2'h0;
      err_count = 0;
      checks = 0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      rd(0, fpc_pkg::ADDR_PROP_CFG, v); check(v, fpc_pkg::PROP_CFG_RESET);
      wr(0, fpc_pkg::ADDR_PROP_CFG, 8'hc0);
      rd(0, fpc_pkg::ADDR_PROP_CFG, v); check(v, 8'hc0);
      rd(0, 4'hf, v); check(v, 8'h00);
      $display("test registers done");
      // warning reports follow bits 7 and 6, never pull the line
      for (int k = 0; k < 2; k++) begin
         wr(0, fpc_pkg::ADDR_PROP_CFG, k ? 8'h3f : 8'hff);
         tw <= 1'b1;
         pgl <= 1'b1;
         repeat (6) @(posedge clk);
         check(linkA.tempWarn[0], !k);
         check(linkA.powerGoodWarn[0], !k);
         check(linkB.tempWarn[0], 1'b0);
         check(linkB.powerGoodWarn[0], 1'b0);
         check(linkA.convPullEn[0], 1'b0);
         tw <= 1'b0;
         pgl <= 1'b0;
      end
      $display("test warnings done");
      rdn <= 1'b1;
      odd <= 1'b1;
      wr(2, fpc_pkg::ADDR_MGR_CTRL, 8'h83);
      wr(0, fpc_pkg::ADDR_CONTROL, 8'h01);
      wr(1, fpc_pkg::ADDR_CONTROL, 8'h01);
      wait_state(1, fpc_pkg::ST_ON);
      linkB.mgrPullEn <= 2'h1;
      wait_state(1, fpc_pkg::ST_REG_OFF);
      check(rdq1, 1'b1);
      check(hsB, 1'b1);
      check(lsB, 1'b0);
      check(ruB, 1'b0);
      linkB.mgrPullEn <= 2'h0;
      $display("test peer pull done");
      // own faults: overvoltage, overcurrent, undervoltage without propagation
      for (int k = 0; k < 3; k++) begin
         wr(0, fpc_pkg::ADDR_PROP_CFG, k == 2 ? 8'h3b : 8'h3f);
         oaz <= 1'b0;
         wait_state(0, fpc_pkg::ST_ON);
         check(hs, 1'b1);
         flt <= 6'h1 << (k == 0 ? fpc_pkg::FLT_OV : k == 1 ? fpc_pkg::FLT_OC : fpc_pkg::FLT_UV);
         wait_state(0, k == 2 ? fpc_pkg::ST_REG_OFF : fpc_pkg::ST_FAST_OFF);
         check(hs, k == 2);
         check(ls, k == 0);
         if (k == 2) check(rdq, 1'b1);
         repeat (6) @(posedge clk);
         check(linkA.convPullEn[0], k != 2);
         check(linkA.faultLineIn[1], k == 2);
         check(feo, k != 2);
         check(cbf, k != 2);
         rd(0, fpc_pkg::ADDR_FAULTS, v); check(v & {2'h0, flt}, {2'h0, flt});
         flt <= 6'h00;
         oaz <= 1'b1;
         n = 0;
         while (ru !== 1'b1 && n < 60) begin
            @(posedge clk);
            #1;
            n++;
         end
         check(n >= 20 && n <= 24, 1'b1);
         wait_state(0, fpc_pkg::ST_ON);
         check(linkA.convPullEn[0], 1'b0);
      end
      // overvoltage ignored while output is below the prebias level
      abp <= 1'b0;
      flt <= 6'h1 << fpc_pkg::FLT_OV;
      repeat (4) @(posedge clk);
      wait_state(0, fpc_pkg::ST_ON);
      check(ls, 1'b0);
      flt <= 6'h00;
      abp <= 1'b1;
      $display("test own faults done");
      tally_and_finish();
   end
endmodule // fault_propagation_control_tb
